/* verilog/fsg_gateway.sv */
// Purpose: Mode and forwarding logic of a fieldbus to serial device gateway
// Assumes: Controller reaches the data areas over AXI4-Lite; switches are pins
// Notes:   Serial side frames are STX, payload, CR, LF at 9600 8N1
module fsg_gateway (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        clkEn,
    // Switches
    input  wire logic [3:0]  address_ones_switch,
    input  wire logic [3:0]  address_tens_switch,
    input  wire logic [3:0]  bitrate_selector_switch,
    input  wire logic [3:0]  deviceSelectSwitch,
    input  wire logic [1:0]  serviceSwitch,
    // Configuration seen by the fieldbus stack
    output logic [6:0]       nodeAddress,
    output logic [3:0]       busBitRate,
    output logic             busEnable,
    output logic             power_indicator,
    // Device and service serial lines
    input  wire logic        devRxd,
    output logic             devTxd,
    input  wire logic        svcRxd,
    output logic             svcTxd,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_STX  = 4'b0010,
        TX_DATA = 4'b0100,
        TX_TAIL = 4'b1000
    } fsg_txs_t;

    typedef struct packed {
        logic [1:0]  syncDev, syncSvc;
        logic [3:0]  sOnes, sTens, sRate, sDevSel;
        logic [1:0]  sSvc;
        logic [1:0]  svcSync1;
        logic        cfgDone;
        logic [6:0]  addr;
        logic [3:0]  rate, devType;
        logic [31:0] param;
        logic [1:0]  mode;
        logic        sendTgl, sendSeen;
        logic        newTgl, bufOvf;
        logic [7:0]  outLen;
        logic [7:0]  inLen;
        logic [6:0]  rxCnt;
        logic        inFrame;
        logic        pending;
        fsg_txs_t    txs;
        logic [6:0]  txIdx;
        logic [1:0]  tailIdx;
        logic        txCmd, txRep;
        logic [22:0] blinkCnt;
        logic        blink;
        logic        awDone, wDone;
        logic [7:0]  awAddr;
        logic [31:0] wData;
        logic        bValid, rValid;
        logic [31:0] rData;
        logic [1:0]  rResp, bResp;
    } fsg_state_t;
    fsg_state_t st_ff, nxt_st;

    // Data areas and collective buffer
    logic [7:0] outArea_ff [fsg_pkg::AREA_BYTES];
    logic [7:0] inArea_ff  [fsg_pkg::BUF_BYTES];
    logic [7:0] colBuf_ff  [fsg_pkg::BUF_BYTES];

    logic       rxValid, txReady, txLine, svcRxValid;
    logic [7:0] rxByte, svcByte, txByte;
    logic       txValid, inRun, inDevSvc, inGwSvc, wrFire, rdFire, ovfSet;

    // Byte of a predefined command; table is chosen by device type
    function automatic logic [7:0] cmdByte(input logic [3:0] dev, input logic [7:0] sel,
                                           input logic [6:0] idx);
        logic [7:0] base;
        base = (dev[0]) ? 8'h2b : 8'h2d;
        case (idx)
            7'h00:   cmdByte = (sel[0]) ? 8'h48 : 8'h2b;
            7'h01:   cmdByte = base;
            default: cmdByte = 8'h76;
        endcase
    endfunction : cmdByte

    // Number of bytes for a command
    function automatic logic [6:0] cmdLen(input logic [3:0] dev, input logic [7:0] sel);
        cmdLen = (dev == 4'h0 || sel == 8'h00) ? 7'h01 : 7'h02;
    endfunction : cmdLen

    fsg_uart_rx u_dev_rx (
        .clock  (clock),
        .arst_n (arst_n),
        .clkEn  (clkEn),
        .rxLine (st_ff.syncDev[1]),
        .rxValid(rxValid),
        .rxByte (rxByte)
    );

    fsg_uart_rx u_svc_rx (
        .clock  (clock),
        .arst_n (arst_n),
        .clkEn  (clkEn),
        .rxLine (st_ff.syncSvc[1]),
        .rxValid(svcRxValid),
        .rxByte (svcByte)
    );

    fsg_uart_tx u_tx (
        .clock  (clock),
        .arst_n (arst_n),
        .clkEn  (clkEn),
        .txValid(txValid),
        .txByte (txByte),
        .txReady(txReady),
        .txLine (txLine)
    );

    // Switch position decode
    assign inRun    = st_ff.sSvc == fsg_pkg::SVC_RUN;
    assign inDevSvc = st_ff.sSvc == fsg_pkg::SVC_DEV;
    assign inGwSvc  = !inRun && !inDevSvc;
    assign wrFire   = st_ff.awDone && st_ff.wDone && !st_ff.bValid;
    assign rdFire   = s_axi_arvalid && !st_ff.rValid;
    // Overflow raised this cycle; it beats a flush in the same cycle
    assign ovfSet   = rxValid && inRun && st_ff.inFrame && rxByte != fsg_pkg::CH_STX &&
                      rxByte != fsg_pkg::CH_CR && rxByte != fsg_pkg::CH_LF &&
                      st_ff.rxCnt == 7'(fsg_pkg::BUF_BYTES);

    // Transmit byte select
    always_comb begin
        txValid = 1'b0;
        txByte  = fsg_pkg::CH_STX;
        case (st_ff.txs)
            TX_STX: begin
                txValid = 1'b1;
            end
            TX_DATA: begin
                txValid = 1'b1;
                if (st_ff.txRep) begin
                    txByte = (st_ff.txIdx == 7'h00) ? {1'b0, st_ff.addr} : {4'h0, st_ff.rate};
                end else if (st_ff.txCmd) begin
                    txByte = cmdByte(st_ff.devType, outArea_ff[0], st_ff.txIdx);
                end else if (st_ff.mode == fsg_pkg::MODE_COLLECT) begin
                    txByte = colBuf_ff[st_ff.txIdx[5:0]];
                end else begin
                    txByte = outArea_ff[st_ff.txIdx[3:0]];
                end
            end
            TX_TAIL: begin
                txValid = 1'b1;
                txByte  = (st_ff.tailIdx == 2'h0) ? fsg_pkg::CH_CR : fsg_pkg::CH_LF;
            end
            default: begin
                txValid = 1'b0;
            end
        endcase
    end

    // Main next-state logic
    always_comb begin
        nxt_st = st_ff;
        nxt_st.syncDev  = {st_ff.syncDev[0], devRxd};
        nxt_st.syncSvc  = {st_ff.syncSvc[0], svcRxd};
        nxt_st.sOnes    = address_ones_switch;
        nxt_st.sTens    = address_tens_switch;
        nxt_st.sRate    = bitrate_selector_switch;
        nxt_st.sDevSel  = deviceSelectSwitch;
        nxt_st.svcSync1 = serviceSwitch;
        nxt_st.sSvc     = st_ff.svcSync1;
        // Startup capture after the synchronisers have filled
        if (!st_ff.cfgDone && st_ff.syncDev[1]) begin
            nxt_st.cfgDone = 1'b1;
            nxt_st.addr    = 7'(st_ff.sTens) * 7'd10 + 7'(st_ff.sOnes);
            nxt_st.rate    = st_ff.sRate;
            nxt_st.devType = st_ff.sDevSel;
        end
        // Power indicator blink timer
        if (inRun) begin
            nxt_st.blinkCnt = 23'h000000;
            nxt_st.blink    = 1'b1;
        end else if (st_ff.blinkCnt == 23'(fsg_pkg::BLINK_CYC - 1)) begin
            nxt_st.blinkCnt = 23'h000000;
            nxt_st.blink    = !st_ff.blink;
        end else begin
            nxt_st.blinkCnt = st_ff.blinkCnt + 23'h000001;
        end
        // Device frame reception
        if (rxValid && inRun) begin
            if (rxByte == fsg_pkg::CH_STX) begin
                nxt_st.inFrame = 1'b1;
                nxt_st.rxCnt   = 7'h00;
            end else if (rxByte == fsg_pkg::CH_LF && st_ff.inFrame) begin
                nxt_st.inFrame = 1'b0;
                nxt_st.inLen   = {1'b0, st_ff.rxCnt};
                nxt_st.newTgl  = !st_ff.newTgl;
            end else if (st_ff.inFrame && rxByte != fsg_pkg::CH_CR) begin
                if (st_ff.rxCnt == 7'(fsg_pkg::BUF_BYTES)) begin
                    nxt_st.bufOvf = 1'b1;
                end else begin
                    nxt_st.rxCnt = st_ff.rxCnt + 7'h01;
                end
            end
        end
        // Service byte asks for a settings report; send toggle edge starts one frame
        if (svcRxValid && inGwSvc && st_ff.txs == TX_IDLE && svcByte != fsg_pkg::CH_LF) begin
            nxt_st.txs      = TX_STX;
            nxt_st.txIdx    = 7'h00;
            nxt_st.tailIdx  = 2'h0;
            nxt_st.txCmd    = 1'b0;
            nxt_st.txRep    = 1'b1;
        end else if (st_ff.sendTgl != st_ff.sendSeen && st_ff.txs == TX_IDLE && inRun) begin
            nxt_st.txRep    = 1'b0;
            nxt_st.sendSeen = st_ff.sendTgl;
            nxt_st.txs      = TX_STX;
            nxt_st.txIdx    = 7'h00;
            nxt_st.tailIdx  = 2'h0;
            nxt_st.txCmd    = st_ff.mode == fsg_pkg::MODE_COMMAND;
        end else if (st_ff.txs == TX_STX && txReady) begin
            nxt_st.txs = TX_DATA;
        end else if (st_ff.txs == TX_DATA && txReady) begin
            nxt_st.txIdx = st_ff.txIdx + 7'h01;
            if (st_ff.txRep ? (st_ff.txIdx == 7'h01) :
                st_ff.txCmd ? (st_ff.txIdx + 7'h01 == cmdLen(st_ff.devType, outArea_ff[0]))
                            : (st_ff.txIdx + 7'h01 >= st_ff.outLen[6:0])) begin
                nxt_st.txs = TX_TAIL;
            end
        end else if (st_ff.txs == TX_TAIL && txReady) begin
            nxt_st.tailIdx = st_ff.tailIdx + 2'h1;
            if (st_ff.tailIdx == 2'h1) begin
                nxt_st.txs = TX_IDLE;
            end
        end
        // AXI4-Lite write channels, taken in either order
        if (s_axi_awvalid && !st_ff.awDone) begin
            nxt_st.awDone = 1'b1;
            nxt_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.wDone) begin
            nxt_st.wDone = 1'b1;
            nxt_st.wData = s_axi_wdata;
        end
        if (wrFire) begin
            nxt_st.awDone = 1'b0;
            nxt_st.wDone  = 1'b0;
            nxt_st.bValid = 1'b1;
            nxt_st.bResp  = fsg_pkg::RESP_OKAY;
            case (st_ff.awAddr)
                fsg_pkg::OFF_CTRL: begin
                    nxt_st.sendTgl = st_ff.wData[fsg_pkg::CTRL_SEND_BIT];
                    nxt_st.mode    = st_ff.wData[fsg_pkg::CTRL_MODE_LSB +: 2];
                    if (st_ff.wData[fsg_pkg::CTRL_FLUSH] && !ovfSet) begin
                        nxt_st.bufOvf = 1'b0;
                    end
                end
                fsg_pkg::OFF_PARAM:  nxt_st.param  = st_ff.wData;
                fsg_pkg::OFF_OUTLEN: nxt_st.outLen = st_ff.wData[7:0];
                default: begin
                    if (st_ff.awAddr < fsg_pkg::OFF_OUTDAT) begin
                        nxt_st.bResp = fsg_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
        if (st_ff.bValid && s_axi_bready) begin
            nxt_st.bValid = 1'b0;
        end
        // AXI4-Lite read channel
        if (rdFire) begin
            nxt_st.rValid = 1'b1;
            nxt_st.rResp  = fsg_pkg::RESP_OKAY;
            nxt_st.rData  = 32'h0000_0000;
            case (s_axi_araddr)
                fsg_pkg::OFF_CTRL:
                    nxt_st.rData = {23'h0, 1'b0, 2'h0, st_ff.mode, 3'h0, st_ff.sendTgl};
                fsg_pkg::OFF_STATUS:
                    nxt_st.rData = {29'h0, st_ff.bufOvf, !inRun, st_ff.newTgl};
                fsg_pkg::OFF_CONFIG:
                    nxt_st.rData = {13'h0, st_ff.devType, st_ff.rate, st_ff.addr, 4'h0};
                fsg_pkg::OFF_PARAM:  nxt_st.rData = st_ff.param;
                fsg_pkg::OFF_OUTLEN: nxt_st.rData = {24'h0, st_ff.outLen};
                fsg_pkg::OFF_INLEN:  nxt_st.rData = {24'h0, st_ff.inLen};
                default: begin
                    if (s_axi_araddr >= fsg_pkg::OFF_INDAT) begin
                        nxt_st.rData = {24'h0, inArea_ff[s_axi_araddr[7:2] - 6'h20]};
                    end else if (s_axi_araddr >= fsg_pkg::OFF_OUTDAT) begin
                        nxt_st.rData = {24'h0, outArea_ff[s_axi_araddr[5:2]]};
                    end else begin
                        nxt_st.rResp = fsg_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
        if (st_ff.rValid && s_axi_rready) begin
            nxt_st.rValid = 1'b0;
        end
    end

    // Arrays: received bytes go into both the input area and the collective buffer in every mode
    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (rxValid && inRun && st_ff.inFrame && rxByte != fsg_pkg::CH_CR &&
                rxByte != fsg_pkg::CH_LF && st_ff.rxCnt < 7'(fsg_pkg::BUF_BYTES)) begin
                inArea_ff[st_ff.rxCnt[5:0]] <= rxByte;
                colBuf_ff[st_ff.rxCnt[5:0]] <= rxByte;
            end
            if (wrFire && st_ff.awAddr >= fsg_pkg::OFF_OUTDAT && st_ff.awAddr < fsg_pkg::OFF_INDAT) begin
                outArea_ff[st_ff.awAddr[5:2]] <= st_ff.wData[7:0];
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
            st_ff.syncDev <= 2'b00;
            st_ff.syncSvc <= 2'b11;
            st_ff.txs     <= TX_IDLE;
            st_ff.param   <= fsg_pkg::PARAM_RESET;
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

    // Serial routing and outputs
    assign devTxd          = inDevSvc ? st_ff.syncSvc[1] :
                             ((inGwSvc || st_ff.txRep) ? 1'b1 : txLine);
    assign svcTxd          = inDevSvc ? st_ff.syncDev[1] : (inGwSvc ? txLine : 1'b1);
    assign busEnable       = inRun && st_ff.cfgDone;
    assign power_indicator = st_ff.blink;
    assign nodeAddress     = st_ff.addr;
    assign busBitRate      = st_ff.rate;
    assign s_axi_awready   = !st_ff.awDone;
    assign s_axi_wready    = !st_ff.wDone;
    assign s_axi_bvalid    = st_ff.bValid;
    assign s_axi_bresp     = st_ff.bResp;
    assign s_axi_arready   = !st_ff.rValid;
    assign s_axi_rvalid    = st_ff.rValid;
    assign s_axi_rdata     = st_ff.rData;
    assign s_axi_rresp     = st_ff.rResp;
endmodule : fsg_gateway

/* pkg/fsg_pkg.sv */
// Purpose: Shared constants for the fieldbus serial gateway mode logic
// Assumes: 25 MHz system clock, 8N1 serial framing
// Notes:   Register map is a small AXI4-Lite window of our own
package fsg_pkg;
    // Clock and serial timing
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned BAUD_DEFAULT  = 9600;
    localparam int unsigned BIT_CYC       = CLK_HZ / BAUD_DEFAULT;
    localparam int unsigned BLINK_MS      = 250;
    localparam int unsigned BLINK_CYC     = (CLK_HZ / 1000) * BLINK_MS;
    // Frame characters
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_CR  = 8'h0d;
    localparam logic [7:0] CH_LF  = 8'h0a;
    // Data area and buffer sizes
    localparam int unsigned AREA_BYTES = 16;
    localparam int unsigned BUF_BYTES  = 64;
    localparam int unsigned CMD_BYTES  = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CONFIG = 8'h08;
    localparam logic [7:0] OFF_PARAM  = 8'h0c;
    localparam logic [7:0] OFF_OUTLEN = 8'h10;
    localparam logic [7:0] OFF_INLEN  = 8'h14;
    localparam logic [7:0] OFF_OUTDAT = 8'h40;
    localparam logic [7:0] OFF_INDAT  = 8'h80;
    // Control register fields
    localparam int unsigned CTRL_SEND_BIT = 0;
    localparam int unsigned CTRL_MODE_LSB = 4;
    localparam int unsigned CTRL_FLUSH    = 8;
    // Status register fields
    localparam int unsigned ST_NEWDATA = 0;
    localparam int unsigned ST_SERVICE = 1;
    localparam int unsigned ST_BUFOVF  = 2;
    // Reset value and response codes
    localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    // Data modes
    typedef enum logic [1:0] {
        MODE_TRANSP  = 2'h0,
        MODE_COLLECT = 2'h1,
        MODE_COMMAND = 2'h2
    } fsg_mode_t;
    // Service switch positions
    typedef enum logic [1:0] {
        SVC_RUN = 2'h0,
        SVC_DEV = 2'h1,
        SVC_GW  = 2'h2
    } fsg_svc_t;
endpackage : fsg_pkg

/* verilog/fsg_uart_tx.sv */
// Purpose: 8N1 serial transmitter, one byte per request
// Assumes: Bit period in system clock cycles is fixed by the package
// Notes:   Ready is high while idle
module fsg_uart_tx (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       clkEn,
    // Byte in
    input  wire logic       txValid,
    input  wire logic [7:0] txByte,
    output logic            txReady,
    // Line
    output logic            txLine
);
    typedef struct packed {
        logic        busy;
        logic [9:0]  shift;
        logic [3:0]  bitCnt;
        logic [11:0] cyc;
        logic        line;
    } fsg_tx_state_t;
    fsg_tx_state_t st_ff, nxt_st;

    // Shift start, data and stop bits out
    always_comb begin
        nxt_st = st_ff;
        if (!st_ff.busy) begin
            nxt_st.line = 1'b1;
            if (txValid) begin
                nxt_st.busy   = 1'b1;
                nxt_st.shift  = {1'b1, txByte, 1'b0};
                nxt_st.bitCnt = 4'h0;
                nxt_st.cyc    = 12'h000;
            end
        end else begin
            nxt_st.line = st_ff.shift[0];
            if (st_ff.cyc == 12'(fsg_pkg::BIT_CYC - 1)) begin
                nxt_st.cyc   = 12'h000;
                nxt_st.shift = {1'b1, st_ff.shift[9:1]};
                nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
                if (st_ff.bitCnt == 4'h9) begin
                    nxt_st.busy = 1'b0;
                end
            end else begin
                nxt_st.cyc = st_ff.cyc + 12'h001;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{busy: 1'b0, shift: 10'h3ff, bitCnt: 4'h0, cyc: 12'h000, line: 1'b1};
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

    assign txReady = !st_ff.busy;
    assign txLine  = st_ff.line;
endmodule : fsg_uart_tx

/* verilog/fsg_uart_rx.sv */
// Purpose: 8N1 serial receiver
// Assumes: Line input is already synchronised
// Notes:   A bad stop bit drops the byte
module fsg_uart_rx (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       clkEn,
    // Line
    input  wire logic       rxLine,
    // Byte out
    output logic            rxValid,
    output logic [7:0]      rxByte
);
    typedef struct packed {
        logic        busy;
        logic [3:0]  bitCnt;
        logic [11:0] cyc;
        logic [7:0]  data;
        logic        valid;
    } fsg_rx_state_t;
    fsg_rx_state_t st_ff, nxt_st;

    // Sample each bit at mid period
    always_comb begin
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        if (!st_ff.busy) begin
            if (!rxLine) begin
                nxt_st.busy   = 1'b1;
                nxt_st.bitCnt = 4'h0;
                nxt_st.cyc    = 12'(fsg_pkg::BIT_CYC / 2);
            end
        end else if (st_ff.cyc == 12'(fsg_pkg::BIT_CYC - 1)) begin
            nxt_st.cyc    = 12'h000;
            nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
            if (st_ff.bitCnt == 4'h0 && rxLine) begin
                nxt_st.busy = 1'b0;           // False start
            end else if (st_ff.bitCnt == 4'h9) begin
                nxt_st.busy  = 1'b0;
                nxt_st.valid = rxLine;        // Stop bit check
            end else if (st_ff.bitCnt != 4'h0) begin
                nxt_st.data = {rxLine, st_ff.data[7:1]};
            end
        end else begin
            nxt_st.cyc = st_ff.cyc + 12'h001;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{busy: 1'b0, bitCnt: 4'h0, cyc: 12'h000, data: 8'h00, valid: 1'b0};
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

    assign rxValid = st_ff.valid;
    assign rxByte  = st_ff.data;
endmodule : fsg_uart_rx

/* testbench/fsg_gateway_monitor.sv */
// Purpose: Port checker for the gateway mode logic
// Assumes: Reset is released in the run position
// Notes:   Bound to every gateway instance
module fsg_gateway_monitor (
    // Clock and reset
    input wire logic       clock,
    input wire logic       arst_n,
    // Switch, lines and pins
    input wire logic [1:0] serviceSwitch,
    input wire logic       svcRxd,
    input wire logic       devTxd,
    input wire logic       busEnable,
    input wire logic       power_indicator,
    input wire logic [6:0] nodeAddress,
    // Read channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic svc;
    logic rdTk;
    // Any service position; read request taken
    assign svc  = serviceSwitch != 2'h0;
    assign rdTk = s_axi_arvalid && !s_axi_rvalid;
    sequence s_brg; (serviceSwitch == 2'h1 && $stable(svcRxd)) [*5]; endsequence
    a_cfg_frozen: assert property (busEnable [*2] |-> $stable(nodeAddress)) else $error("moved");
    a_svc_busoff: assert property (svc [*3] |-> !busEnable) else $error("bus on");
    a_dev_bridge: assert property (s_brg |-> devTxd == svcRxd) else $error("no bridge");
    a_run_steady: assert property (busEnable [*3] |-> power_indicator) else $error("dark");
    a_slow_blink: assert property (svc && $changed(power_indicator)
        |=> $stable(power_indicator)) else $error("fast blink");
    a_rd_answer: assert property (rdTk |=> s_axi_rvalid) else $error("no answer");
    a_rd_unmap: assert property (rdTk && s_axi_araddr == 8'h30
        |=> s_axi_rresp == 2'h2) else $error("no error");
    a_rd_mapped: assert property (rdTk && s_axi_araddr == 8'h08
        |=> s_axi_rresp == 2'h0) else $error("bad okay");
    // Main scenarios
    c_dev_svc: cover property (serviceSwitch == 2'h1 [*5]);
    c_gw_svc: cover property (serviceSwitch == 2'h2 [*2]);
    c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : fsg_gateway_monitor
bind fsg_gateway fsg_gateway_monitor mon (.*);

/* testbench/fsg_dev_model.sv */
// Purpose: Serial device sending one empty frame on request
// Assumes: 8N1 line at the default rate, idle high
// Notes:   Empty payload keeps the run short
module fsg_dev_model (
    // Clock and request
    input wire logic clock,
    input wire logic go,
    // Line toward the gateway
    output logic     devLine
);
    timeunit 1ns;
    timeprecision 1ns;
    // One character: start, low bit first, stop
    task automatic put(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            devLine <= f[i];
            repeat (fsg_pkg::BIT_CYC) @(posedge clock);
        end
    endtask : put
    // Start character then the terminator pair
    initial begin
        devLine = 1'b1;
        @(posedge go);
        put(fsg_pkg::CH_STX);
        put(fsg_pkg::CH_CR);
        put(fsg_pkg::CH_LF);
    end
endmodule : fsg_dev_model

/* testbench/test_fsg_gateway.sv */
// Purpose: Directed test of the gateway mode logic
// Assumes: Inputs change just after the rising edge
// Notes:   One empty device frame keeps the run short
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_fsg_gateway;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, arst_n = 1'b0, clkEn = 1'b1, go = 1'b0, svcRxd = 1'b1;
    logic        devRxd, devTxd, svcTxd, busEnable, power_indicator, s_axi_rvalid;
    logic [3:0]  address_ones_switch = 4'h3, address_tens_switch = 4'h4, s_axi_wstrb = 4'hf;
    logic [3:0]  bitrate_selector_switch = 4'h5, deviceSelectSwitch = 4'h6, busBitRate;
    logic [1:0]  serviceSwitch = 2'h0, s_axi_bresp, s_axi_rresp, r;
    logic [6:0]  nodeAddress;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, s;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    int          miscompares = 0, n_checks = 0;
    // Design, serial device and clock
    fsg_gateway dut (.*);
    fsg_dev_model dev (.clock(clock), .go(go), .devLine(devRxd));
    always #20 clock = ~clock;
    // Counts, verdict and end of run
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // One register access; leaves read data in d and response in r
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        logic [2:0] tk;
        @(posedge clock);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wr, wr, !wr};
        {s_axi_bready, s_axi_rready} <= {wr, !wr};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wd};
        for (n = 0; n < 50; n++) begin
            @(negedge clock);
            tk = {s_axi_awready, s_axi_wready, s_axi_arready};
            {d, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
            if ((wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1) break;
            @(posedge clock);
            {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} & ~tk;
        end
        @(posedge clock);
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (n == 50) begin miscompares++; results(); end
    endtask : axi
    // Main sequence
    initial begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (80) @(posedge clock);
        {address_ones_switch, deviceSelectSwitch} <= 8'h91;
        repeat (8) @(posedge clock);
        `CHK("nodeAddress", 7'h2b, nodeAddress)
        `CHK("busBitRate", 4'h5, busBitRate)
        axi(1'b0, fsg_pkg::OFF_CONFIG, 32'h0);
        `CHK("config", 32'h0003_2ab0, d)
        axi(1'b1, fsg_pkg::OFF_PARAM, 32'h1234_abcd);
        axi(1'b0, fsg_pkg::OFF_PARAM, 32'h0);
        `CHK("param", 32'h1234_abcd, d)
        axi(1'b0, 8'h30, 32'h0);
        `CHK("unmapped", fsg_pkg::RESP_SLVERR, r)
        $display("test config done");
        {serviceSwitch, svcRxd} <= {fsg_pkg::SVC_DEV, 1'b0};
        repeat (8) @(posedge clock);
        `CHK("busEnable", 1'b0, busEnable)
        `CHK("devTxd", 1'b0, devTxd)
        svcRxd <= 1'b1;
        axi(1'b0, fsg_pkg::OFF_STATUS, 32'h0);
        `CHK("serviceFlag", 1'b1, d[fsg_pkg::ST_SERVICE])
        serviceSwitch <= fsg_pkg::SVC_GW;
        repeat (8) @(posedge clock);
        axi(1'b0, fsg_pkg::OFF_STATUS, 32'h0);
        `CHK("serviceFlag", 1'b1, d[fsg_pkg::ST_SERVICE])
        `CHK("svcIdle", 1'b1, svcTxd)
        svcRxd <= 1'b0;
        repeat (9 * fsg_pkg::BIT_CYC + fsg_pkg::BIT_CYC / 4) @(posedge clock);
        svcRxd <= 1'b1;
        repeat (fsg_pkg::BIT_CYC) @(posedge clock);
        `CHK("report", 1'b0, svcTxd)
        serviceSwitch <= fsg_pkg::SVC_RUN;
        repeat (8) @(posedge clock);
        axi(1'b0, fsg_pkg::OFF_STATUS, 32'h0);
        `CHK("serviceFlag", 1'b0, d[fsg_pkg::ST_SERVICE])
        `CHK("power", 1'b1, power_indicator)
        `CHK("busEnable", 1'b1, busEnable)
        $display("test service done");
        s = d;
        go <= 1'b1;
        repeat (30 * fsg_pkg::BIT_CYC + 40) @(posedge clock);
        axi(1'b0, fsg_pkg::OFF_STATUS, 32'h0);
        `CHK("newData", ~s[fsg_pkg::ST_NEWDATA], d[fsg_pkg::ST_NEWDATA])
        axi(1'b0, fsg_pkg::OFF_INLEN, 32'h0);
        `CHK("inLen", 32'h0, d)
        axi(1'b1, fsg_pkg::OFF_CTRL, 32'h0000_0010);
        axi(1'b0, fsg_pkg::OFF_CTRL, 32'h0);
        `CHK("mode", 32'h0000_0010, d)
        $display("test frame done");
        results();
    end
endmodule : test_fsg_gateway
